// ### logic/dlc_top.sv
/*
 * display list coprocessor: fetches two-word instructions from chip memory
 * and performs wait, move and skip against the beam counters.
 * assumes the memory arbiter always grants a request raised in an odd
 * cycle, returns the word in the following cycle, and that beam counters,
 * cycle parity and blit busy come from logic on the same clock.
 */
//
// Behaviour
// - fetch instructions only from chip memory
// - waiting compares beam, raises no requests
// - after wait, steal cycles over cpu/blit
// - requests only in odd memory cycles
// - coprocessor beats processor and blit engine
// - decode wait, move and skip only
// - two 16-bit words fetched per instruction
// - move and skip take four cycles
// - wait takes three requests, eight cycles at least
// - first word addresses, second word is data
// - addresses 0x20 and up always writable
// - 0x10 to 0x20 need enable bit
// - never write below 0x10
// - write chip registers only, never memory
// - jump strobe fires on read or write
// - wait word fields and enable bits
// - masked beam at or past position ends wait
// - horizontal lsb excluded from comparison
`timescale 1ns/10ps
`default_nettype none

module dlc_top
  import dlc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // control port
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // chip memory dma
  input wire logic mem_cycle_odd,
  output logic dma_req,
  output logic dma_prio,
  output logic [18:0] dma_addr,
  input wire logic [15:0] dma_rdata,
  // chip register writes
  output logic reg_wr_stb,
  output logic [8:0] reg_wr_addr,
  output logic [15:0] reg_wr_data,
  // beam and blit status
  input wire logic [7:0] beam_vpos,
  input wire logic [7:0] beam_hpos,
  input wire logic blit_busy
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  dlc_state_t state_r;
  logic [18:0] pc_r;
  logic [15:0] first_instruction_word_r;
  logic [15:0] second_instruction_word_r;
  logic [15:0] coprocessor_control_reg_r;
  logic [18:0] list_addr_r;
  logic move_refused_r;
  logic dma_req_r;
  logic [18:0] dma_addr_r;
  logic reg_wr_stb_r;
  logic [8:0] reg_wr_addr_r;
  logic [15:0] reg_wr_data_r;
  logic [15:0] reg_rdata_r;
  logic list_jump_strobe_two;
  logic [15:0] cmp_enable;
  logic beam_reached;
  logic wait_done;
  logic [8:0] move_target;
  logic move_allowed;
  logic is_wait;
  logic is_skip;

  // ****************************************************************
  // beam comparison
  // ****************************************************************
  // the second word is still on the bus while a skip is judged
  assign cmp_enable = (state_r == DLC_S_F2_DAT) ? dma_rdata : second_instruction_word_r;

  dlc_beam_cmp u_cmp (
    .beam_vpos(beam_vpos),
    .beam_hpos(beam_hpos),
    .pos_word(first_instruction_word_r),
    .enable_word(cmp_enable),
    .reached(beam_reached)
  );

  // a clear blit-finished disable bit also holds the wait until blit idle
  assign wait_done = beam_reached &
    (second_instruction_word_r[DLC_BFD_BIT] | ~blit_busy);

  // ****************************************************************
  // decode
  // ****************************************************************
  // bit 0 of the first word splits move from the rest; bit 0 of the
  // second word splits wait from skip
  always_comb begin
    is_wait = first_instruction_word_r[DLC_TYPE_BIT] & ~dma_rdata[DLC_TYPE_BIT];
    is_skip = first_instruction_word_r[DLC_TYPE_BIT] & dma_rdata[DLC_TYPE_BIT];
    move_target = {first_instruction_word_r[8:1], 1'b0};
    if (move_target >= DLC_REG_OPEN) begin
      move_allowed = 1'b1;
    end else if (move_target >= DLC_REG_GUARD) begin
      move_allowed = coprocessor_control_reg_r[DLC_CTRL_LOWEN_BIT];
    end else begin
      move_allowed = 1'b0;
    end
  end

  // ****************************************************************
  // jump strobe
  // ****************************************************************
  // either access kind restarts the list, so a read-modify-write from
  // software would fire it twice
  assign list_jump_strobe_two = (reg_wr | reg_rd) && (reg_addr == DLC_OFF_JUMP);

  // ****************************************************************
  // sequencer
  // ****************************************************************
  // a request is armed in an even cycle so the registered strobe stands
  // in the odd cycle that follows; data comes back one cycle later
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_r <= DLC_S_IDLE;
      pc_r <= DLC_LIST_RST;
      first_instruction_word_r <= DLC_ZERO_WORD;
      second_instruction_word_r <= DLC_ZERO_WORD;
      dma_req_r <= 1'b0;
      dma_addr_r <= DLC_LIST_RST;
    end else if (list_jump_strobe_two) begin
      // restart wins over whatever the sequencer was doing
      state_r <= DLC_S_FETCH;
      pc_r <= list_addr_r;
      dma_req_r <= 1'b0;
    end else begin
      dma_req_r <= 1'b0;
      case (state_r)
        DLC_S_IDLE: begin
          state_r <= DLC_S_IDLE;
        end
        DLC_S_FETCH: begin
          if (!mem_cycle_odd) begin
            dma_req_r <= 1'b1;
            dma_addr_r <= pc_r;
            state_r <= DLC_S_F1_REQ;
          end
        end
        DLC_S_F1_REQ: begin
          state_r <= DLC_S_F1_DAT;
        end
        DLC_S_F1_DAT: begin
          // even cycle: capture first word and arm the second fetch
          first_instruction_word_r <= dma_rdata;
          dma_req_r <= 1'b1;
          dma_addr_r <= pc_r + DLC_STEP_WORD;
          state_r <= DLC_S_F2_REQ;
        end
        DLC_S_F2_REQ: begin
          state_r <= DLC_S_F2_DAT;
        end
        DLC_S_F2_DAT: begin
          second_instruction_word_r <= dma_rdata;
          if (is_wait) begin
            // no request while parked on the beam
            pc_r <= pc_r + DLC_STEP_INSTR;
            state_r <= DLC_S_WAITING;
          end else begin
            // move or skip: fetch of the next instruction is armed at
            // once, so the instruction spans exactly four cycle times
            if (is_skip && beam_reached) begin
              pc_r <= pc_r + DLC_STEP_SKIP;
              dma_addr_r <= pc_r + DLC_STEP_SKIP;
            end else begin
              pc_r <= pc_r + DLC_STEP_INSTR;
              dma_addr_r <= pc_r + DLC_STEP_INSTR;
            end
            dma_req_r <= 1'b1;
            state_r <= DLC_S_F1_REQ;
          end
        end
        DLC_S_WAITING: begin
          if (wait_done) begin
            state_r <= DLC_S_WAKE;
          end
        end
        DLC_S_WAKE: begin
          // one extra odd slot is spent waking before the next fetch
          if (!mem_cycle_odd) begin
            dma_req_r <= 1'b1;
            dma_addr_r <= pc_r;
            state_r <= DLC_S_WAKE_REQ;
          end
        end
        DLC_S_WAKE_REQ: begin
          state_r <= DLC_S_FETCH;
        end
        default: begin
          state_r <= DLC_S_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // chip register writes
  // ****************************************************************
  // the only store path: no memory write port exists at all
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reg_wr_stb_r <= 1'b0;
      reg_wr_addr_r <= 9'h000;
      reg_wr_data_r <= DLC_ZERO_WORD;
      move_refused_r <= 1'b0;
    end else begin
      reg_wr_stb_r <= 1'b0;
      if (!list_jump_strobe_two && state_r == DLC_S_F2_DAT &&
          !first_instruction_word_r[DLC_TYPE_BIT]) begin
        if (move_allowed) begin
          reg_wr_stb_r <= 1'b1;
          reg_wr_addr_r <= move_target;
          reg_wr_data_r <= dma_rdata;
          move_refused_r <= 1'b0;
        end else begin
          // a refused move is dropped silently; only status shows it
          move_refused_r <= 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // control port writes
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      coprocessor_control_reg_r <= DLC_CTRL_RST;
      list_addr_r <= DLC_LIST_RST;
    end else if (reg_wr) begin
      if (reg_addr == DLC_OFF_CTRL) begin
        coprocessor_control_reg_r <= reg_wdata;
      end else if (reg_addr == DLC_OFF_LIST_HI) begin
        list_addr_r[18:16] <= reg_wdata[DLC_LIST_HI_W-1:0];
      end else if (reg_addr == DLC_OFF_LIST_LO) begin
        list_addr_r[15:0] <= reg_wdata;
      end
    end
  end

  // ****************************************************************
  // control port reads
  // ****************************************************************
  // read data stand one cycle after the strobe and only then
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata_r <= DLC_ZERO_WORD;
    end else if (reg_rd) begin
      if (reg_addr == DLC_OFF_CTRL) begin
        reg_rdata_r <= coprocessor_control_reg_r;
      end else if (reg_addr == DLC_OFF_LIST_HI) begin
        reg_rdata_r <= {13'h0000, list_addr_r[18:16]};
      end else if (reg_addr == DLC_OFF_LIST_LO) begin
        reg_rdata_r <= list_addr_r[15:0];
      end else if (reg_addr == DLC_OFF_STATUS) begin
        reg_rdata_r <= {11'h000, move_refused_r, state_r};
      end else if (reg_addr == DLC_OFF_PC_HI) begin
        reg_rdata_r <= {13'h0000, pc_r[18:16]};
      end else if (reg_addr == DLC_OFF_PC_LO) begin
        reg_rdata_r <= pc_r[15:0];
      end else begin
        reg_rdata_r <= DLC_ZERO_WORD; // jump strobe and unmapped read zero
      end
    end else begin
      reg_rdata_r <= DLC_ZERO_WORD;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign reg_rdata = reg_rdata_r;
  assign dma_req = dma_req_r;
  assign dma_prio = dma_req_r;
  assign dma_addr = dma_addr_r;
  assign reg_wr_stb = reg_wr_stb_r;
  assign reg_wr_addr = reg_wr_addr_r;
  assign reg_wr_data = reg_wr_data_r;

endmodule

`default_nettype wire

// ### logic/dlc_pkg.sv
/*
 * constants shared by the display list coprocessor: register offsets of the
 * control port, field positions of instruction words, protected register
 * limits, address steps and the sequencer states.
 * assumes a 16-bit chip memory and a 16-bit chip register bus.
 */
`default_nettype none

package dlc_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int DLC_DATA_W = 16;
  localparam int DLC_CHIP_AW = 19; // word address inside chip memory
  localparam int DLC_REG_AW = 9; // chip register byte address
  localparam int DLC_OFF_W = 3;

  // ****************************************************************
  // control port offsets
  // ****************************************************************
  localparam logic [2:0] DLC_OFF_CTRL = 3'h0;
  localparam logic [2:0] DLC_OFF_LIST_HI = 3'h1;
  localparam logic [2:0] DLC_OFF_LIST_LO = 3'h2;
  localparam logic [2:0] DLC_OFF_JUMP = 3'h3;
  localparam logic [2:0] DLC_OFF_STATUS = 3'h4;
  localparam logic [2:0] DLC_OFF_PC_HI = 3'h5;
  localparam logic [2:0] DLC_OFF_PC_LO = 3'h6;

  // ****************************************************************
  // fields and reset values
  // ****************************************************************
  localparam int DLC_CTRL_LOWEN_BIT = 1; // low-register write enable
  localparam logic [15:0] DLC_CTRL_RST = 16'h0000;
  localparam logic [15:0] DLC_ZERO_WORD = 16'h0000;
  localparam logic [18:0] DLC_LIST_RST = 19'h00000;
  localparam int DLC_TYPE_BIT = 0; // bit 0 of either word selects the operation
  localparam int DLC_BFD_BIT = 15; // blit-finished disable in second word
  localparam int DLC_LIST_HI_W = 3;

  // ****************************************************************
  // register protection and address steps
  // ****************************************************************
  localparam logic [8:0] DLC_REG_OPEN = 9'h020; // always writable at and above
  localparam logic [8:0] DLC_REG_GUARD = 9'h010; // writable with enable at and above
  localparam logic [18:0] DLC_STEP_WORD = 19'h00001;
  localparam logic [18:0] DLC_STEP_INSTR = 19'h00002;
  localparam logic [18:0] DLC_STEP_SKIP = 19'h00004;

  // ****************************************************************
  // sequencer states
  // ****************************************************************
  typedef enum logic [3:0] {
    DLC_S_IDLE = 4'h0,
    DLC_S_FETCH = 4'h1,
    DLC_S_F1_REQ = 4'h2,
    DLC_S_F1_DAT = 4'h3,
    DLC_S_F2_REQ = 4'h4,
    DLC_S_F2_DAT = 4'h5,
    DLC_S_WAITING = 4'h6,
    DLC_S_WAKE = 4'h7,
    DLC_S_WAKE_REQ = 4'h8
  } dlc_state_t;

endpackage

`default_nettype wire

// ### logic/dlc_beam_cmp.sv
/*
 * masked beam position comparator of the display list coprocessor.
 * assumes beam counters run on the same clock as the caller; the result is
 * combinational so a skip can be judged in the cycle its second word lands.
 */
`timescale 1ns/10ps
`default_nettype none

module dlc_beam_cmp
  import dlc_pkg::*;
(
  // beam counters
  input wire logic [7:0] beam_vpos,
  input wire logic [7:0] beam_hpos,
  // instruction words
  input wire logic [15:0] pos_word,
  input wire logic [15:0] enable_word,
  // result
  output logic reached
);

  logic [14:0] beam_key;
  logic [14:0] pos_key;
  logic [14:0] mask;

  // ****************************************************************
  // compare
  // ****************************************************************
  // the vertical top bit has no enable and is always compared; the
  // horizontal lsb is dropped, so only even positions matter
  always_comb begin
    beam_key = {beam_vpos, beam_hpos[7:1]};
    pos_key = {pos_word[15:8], pos_word[7:1]};
    mask = {1'b1, enable_word[14:8], enable_word[7:1]};
    // eight-bit line field wraps after 255 by width alone
    reached = (beam_key & mask) >= (pos_key & mask);
  end

endmodule

`default_nettype wire

// ### bench/dlc_top_sva.sv
/*
 * port assertions for the display list coprocessor top.
 * assumes a single clock and the synchronous active-low reset.
 */
`timescale 1ns/10ps
`default_nettype none

module dlc_top_sva (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // control port
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  // dma and register writes
  input wire logic mem_cycle_odd,
  input wire logic dma_req,
  input wire logic dma_prio,
  input wire logic [15:0] dma_rdata,
  input wire logic reg_wr_stb,
  input wire logic [8:0] reg_wr_addr,
  input wire logic [15:0] reg_wr_data
);
  // ****************************************************************
  // helper and properties
  // ****************************************************************
  // shadow of the low-register enable, so guarded writes can be judged
  logic lowen_r;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      lowen_r <= 1'b0;
    end else if (reg_wr && reg_addr == 3'h0) begin
      lowen_r <= reg_wdata[1];
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  chk_req_odd_only: assert property (dma_req |-> mem_cycle_odd)
    else $error("dma request outside an odd cycle");
  chk_prio_with_req: assert property (dma_prio == dma_req)
    else $error("priority flag differs from request");
  chk_req_spacing: assert property (dma_req |=> !dma_req)
    else $error("dma requests back to back");
  chk_move_spacing: assert property (reg_wr_stb |=> (!reg_wr_stb) [*3])
    else $error("moves closer than four cycles");
  chk_never_below: assert property (reg_wr_stb |-> reg_wr_addr >= 9'h010)
    else $error("write below the protected floor");
  chk_guard_enable: assert property (reg_wr_stb && reg_wr_addr < 9'h020 |-> lowen_r)
    else $error("guarded register written without enable");
  chk_move_data: assert property (reg_wr_stb |-> reg_wr_data == $past(dma_rdata))
    else $error("move data is not the second word");
  chk_word_fetched: assert property (reg_wr_stb |-> $past(dma_req, 2))
    else $error("move without a second word fetch");
  chk_jump_halts: assert property ((reg_wr || reg_rd) && reg_addr == 3'h3
    |=> !dma_req)
    else $error("request right after a jump strobe");
endmodule

`default_nettype wire

// ### bench/dlc_mem_model.sv
/*
 * chip memory seen through the dma slot, plus the odd/even slot marker.
 * assumes the bench loads mem directly; only the low 8 address bits decode.
 */
`timescale 1ns/10ps
`default_nettype none

module dlc_mem_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // dma side
  input wire logic dma_req,
  input wire logic [18:0] dma_addr,
  output logic [15:0] dma_rdata,
  output logic mem_cycle_odd
);
  logic [15:0] mem [0:255];

  // slots alternate from the first edge after reset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mem_cycle_odd <= 1'b0;
    end else begin
      mem_cycle_odd <= !mem_cycle_odd;
    end
  end

  // every request is granted; between grants the bus shows junk
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dma_rdata <= 16'h0000;
    end else if (dma_req) begin
      dma_rdata <= mem[dma_addr[7:0]];
    end else begin
      dma_rdata <= ~dma_rdata;
    end
  end
endmodule

`default_nettype wire

// ### bench/test_display_list_coprocessor.sv
/*
 * bench for the coprocessor: control port, moves, protection, waits, skip.
 * assumes the memory model answers every odd-cycle request.
 */
`timescale 1ns/10ps
`default_nettype none

module test_display_list_coprocessor;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic blit_busy = 1'b0;
  logic [7:0] beam_vpos = 8'h00;
  logic [7:0] beam_hpos = 8'h00;
  logic [15:0] reg_rdata, dma_rdata, reg_wr_data;
  logic mem_cycle_odd, dma_req, dma_prio, reg_wr_stb;
  logic [18:0] dma_addr;
  logic [8:0] reg_wr_addr;
  int err_total, checks, cyc, req_cnt;
  logic [24:0] wr_log [$];
  logic [18:0] req_log [$];

  always #2 mclk = ~mclk;

  dlc_top dut_u (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_cycle_odd(mem_cycle_odd),
    .dma_req(dma_req), .dma_prio(dma_prio), .dma_addr(dma_addr), .dma_rdata(dma_rdata),
    .reg_wr_stb(reg_wr_stb), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data),
    .beam_vpos(beam_vpos), .beam_hpos(beam_hpos), .blit_busy(blit_busy));
  dlc_mem_model mem_u (.mclk(mclk), .rst_n(rst_n), .dma_req(dma_req), .dma_addr(dma_addr),
    .dma_rdata(dma_rdata), .mem_cycle_odd(mem_cycle_odd));

  // ****************************************************************
  // monitors, timeout and verdict
  // ****************************************************************
  // log register writes and fetch addresses as they leave the block
  always @(posedge mclk) begin
    cyc++;
    if (reg_wr_stb === 1'b1) wr_log.push_back({reg_wr_addr, reg_wr_data});
    if (dma_req === 1'b1) begin
      req_cnt++;
      req_log.push_back(dma_addr);
    end
    if (cyc == 20000) begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [24:0] exp, input logic [24:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // ****************************************************************
  // bus and list helpers
  // ****************************************************************
  // a spare cycle after each strobe keeps strobes from being driven twice in one step
  task automatic reg_write(input logic [2:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic reg_read(input logic [2:0] a, input logic [15:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    check("read data", {9'h000, exp}, {9'h000, reg_rdata});
    @(posedge mclk);
  endtask

  task automatic put(input int at, input logic [15:0] w1, input logic [15:0] w2);
    mem_u.mem[at] = w1;
    mem_u.mem[at + 1] = w2;
  endtask

  task automatic start(input logic [15:0] base, input logic by_read);
    reg_write(3'h1, 16'h0000);
    reg_write(3'h2, base);
    wr_log.delete();
    req_log.delete();
    req_cnt = 0;
    if (by_read) reg_read(3'h3, 16'h0000);
    else reg_write(3'h3, 16'h0000);
  endtask

  // bounded wait for n writes, then a quiet spell that must add none
  task automatic wait_moves(input int n);
    for (int i = 0; i < 200 && wr_log.size() < n; i++) @(posedge mclk);
    repeat (24) @(posedge mclk);
    check("move count", 25'(n), 25'(wr_log.size()));
  endtask

  task automatic exp_wr(input int i, input logic [24:0] e);
    check("move", e, (i < wr_log.size()) ? wr_log[i] : 25'h0);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic test_ctrl();
    reg_read(3'h0, 16'h0000);
    reg_write(3'h4, 16'h00ff);
    reg_read(3'h4, 16'h0000);
    reg_write(3'h0, 16'h0002);
    reg_read(3'h0, 16'h0002);
    // read data stand one cycle only, then fall back to zero
    #1;
    check("read idle", 25'h0, 25'(reg_rdata));
    @(posedge mclk);
    // only three bits of the high list half are kept
    reg_write(3'h1, 16'hffff);
    reg_read(3'h1, 16'h0007);
    reg_write(3'h2, 16'h1234);
    reg_read(3'h2, 16'h1234);
    reg_read(3'h5, 16'h0000);
    reg_read(3'h7, 16'h0000);
    $display("done control port");
  endtask

  // open, guarded and forbidden targets, with the enable off then on
  task automatic test_moves();
    int n;
    put(16'h0010, 16'h0040, 16'h1234);
    put(16'h0012, 16'h0012, 16'haaaa);
    put(16'h0014, 16'h0008, 16'h5555);
    put(16'h0016, 16'h0044, 16'hbeef);
    put(16'h0018, 16'hffff, 16'hfffe);
    for (int en = 0; en < 2; en++) begin
      reg_write(3'h0, en ? 16'h0002 : 16'h0000);
      start(16'h0010, 1'b0);
      wait_moves(en ? 3 : 2);
      exp_wr(0, {9'h040, 16'h1234});
      exp_wr(1, en ? {9'h012, 16'haaaa} : {9'h044, 16'hbeef});
      for (int k = 0; k < 4; k++) begin
        check("fetch", 25'(16'h0010 + k), 25'(req_log[k]));
      end
      n = req_cnt;
      reg_read(3'h4, 16'h0006);
      // parked on the closing wait, so the counter sits one instruction past it
      reg_read(3'h6, 16'h001a);
      reg_read(3'h5, 16'h0000);
      reg_read(3'h2, 16'h0010);
      repeat (40) @(posedge mclk);
      check("idle requests", 25'(n), 25'(req_cnt));
    end
    $display("done moves");
  endtask

  task automatic test_wait();
    put(16'h0020, 16'h4001, 16'h7f00);
    put(16'h0022, 16'h0050, 16'h7777);
    put(16'h0024, 16'h0023, 16'h80fe);
    put(16'h0026, 16'h0052, 16'h8888);
    put(16'h0028, 16'hffff, 16'hfffe);
    beam_vpos <= 8'h10;
    beam_hpos <= 8'h21;
    blit_busy <= 1'b1;
    start(16'h0020, 1'b0);
    wait_moves(0);
    check("wait requests", 25'h2, 25'(req_cnt));
    beam_vpos <= 8'h40;
    wait_moves(0);
    blit_busy <= 1'b0;
    wait_moves(1);
    exp_wr(0, {9'h050, 16'h7777});
    check("wake requests", 25'h7, 25'(req_cnt));
    beam_hpos <= 8'h22;
    wait_moves(2);
    exp_wr(1, {9'h052, 16'h8888});
    $display("done waits");
  endtask

  // skip taken when the beam is past, not taken when short of it
  task automatic test_skip();
    put(16'h0030, 16'h1001, 16'h7f01);
    put(16'h0032, 16'h0060, 16'h1111);
    put(16'h0034, 16'h0062, 16'h2222);
    put(16'h0036, 16'hffff, 16'hfffe);
    for (int r = 0; r < 2; r++) begin
      beam_vpos <= r ? 8'h05 : 8'h20;
      @(posedge mclk);
      start(16'h0030, 1'b1);
      wait_moves(r ? 2 : 1);
      exp_wr(r, {9'h062, 16'h2222});
    end
    $display("done skip");
  endtask

  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    test_ctrl();
    test_moves();
    test_wait();
    test_skip();
    report_and_stop();
  end
endmodule

bind dlc_top dlc_top_sva chk_u (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .mem_cycle_odd(mem_cycle_odd),
  .dma_req(dma_req), .dma_prio(dma_prio), .dma_rdata(dma_rdata), .reg_wr_stb(reg_wr_stb),
  .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data));

`default_nettype wire
